// ===== hw/isc_sys_ctrl.sv
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// [R1] Wake-up timer counts the internal 1 kHz tick or external oscillator tick.
// [R2] In stop2 and stop1 only the internal 1 kHz tick advances the timer.
// [R3] Three-bit period select picks one of seven wake-up periods.
// [R4] Period select of zero disables the timer; no wake-up events.
// [R5] Timer has read-only expiry flag, write-one acknowledge, local interrupt enable.
// [R6] Software writes zero to reserved bit 5 of the pin register.
// [R7] Pull disable bit 6 turns the internal pull-up off while the pin is enabled.
// [R8] Pin enable bit 4 makes the pin an interrupt request input.
// [R9] Event flag bit 3 is set when a qualifying pin event is seen.
// [R10] Writing 1 to bit 2 clears the event flag; bit 2 reads zero.
// [R11] In edge-and-level mode, acknowledge cannot clear the flag while pin low.
// [R12] Interrupt enable bit 1 requests an interrupt whenever the event flag is set.
// [R13] Mode bit 0: falling edges only, or falling edges and low levels.
// [R14] Debug host forced reset clears every reset cause bit.
// [R15] Any write to the reset cause address restarts the watchdog, contents kept. The code restarts it only for writes that strobe byte lane 0.
// [R16] Power-on reset leaves power-on bit 7 and low-voltage bit 1 set.
// [R17] Other resets clear bits 7 and 1; each source bit shows activity on the last cycle of reset.
// [R18] Bit 6 records a reset from the active-low external reset pin.
// [R19] Bit 5 records a watchdog reset, impossible while watchdog is disabled.
// [R20] Bit 4 records illegal opcode, including disabled stop or background instructions.
// [R21] Bit 3 records an access to an unimplemented address.
// [R22] Bit 1 records a low-voltage reset when enabled and supply below trip.
// [R23] The low-voltage detector holds reset; this block only records the cause.
// [R24] Period divider ratios per select code are named constants.
// [R25] Reserved reset cause bits and unused pin register bits read zero.
module isc_sys_ctrl (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// AXI4-Lite write address
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [isc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic [2:0] i_s_axi_awprot,
	// AXI4-Lite write data
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [isc_pkg::DATA_W-1:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	// AXI4-Lite write response
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	// AXI4-Lite read address
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [isc_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input wire logic [2:0] i_s_axi_arprot,
	// AXI4-Lite read data
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [isc_pkg::DATA_W-1:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	// External interrupt pin, low asserted
	input wire logic i_ext_irq_pin_b,
	output logic o_pin_pullup_en,
	output logic o_pin_irq,
	// Wake-up timer clock ticks and power mode
	input wire logic i_lpo_1khz_tick,
	input wire logic i_external_oscillator_tick,
	input wire logic i_ext_ref_stop_keepalive,
	input wire isc_pkg::isc_stop_e i_stop_mode,
	output logic o_wakeup_irq,
	// Reset sources, sampled while i_rst_b is low
	input wire logic i_power_on_reset,
	input wire logic i_supply_below_trip,
	input wire logic i_low_voltage_reset_enable,
	input wire logic i_debug_force_reset_bit,
	input wire logic i_ext_reset_pin_b,
	input wire logic i_watchdog_timeout,
	input wire logic i_watchdog_enable,
	input wire logic i_illegal_opcode,
	input wire logic i_stop_exec,
	input wire logic i_stop_instruction_enable,
	input wire logic i_background_instruction,
	input wire logic i_background_mode_enable,
	input wire logic i_illegal_address,
	output logic o_watchdog_restart
);
	import isc_pkg::*;

	// Bus side state
	logic aw_free_q, w_free_q, w_lane0_q, bvalid_q, arready_q, rvalid_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [REG_W-1:0] w_data_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] bresp_q, rresp_q;

	// Register and output flop state
	logic pin_pull_disable_q, pin_func_enable_q, pin_event_flag_q, pin_irq_enable_q;
	logic pin_detect_mode_q, pin_prev_q, wake_clksel_q, wake_irq_enable_q, wake_flag_q;
	logic pin_pullup_en_q, pin_irq_q, wakeup_irq_q, watchdog_restart_q;
	logic [REG_W-1:0] rcs_q;
	logic [WAKE_PERIOD_W-1:0] wake_period_q;
	logic [WAKE_CNT_W-1:0] wake_cnt_q;

	// Decoded write strobes and helpers
	logic wr_fire, wr_hit_pin, wr_hit_rcs, wr_hit_wake, wr_mapped, rd_fire, rd_mapped;
	logic pin_low, pin_event, pin_ack, wake_ack, wake_tick, ext_ok, wake_expire, wake_restart;
	logic [REG_W-1:0] rd_byte, rcs_sources;
	logic [ADDR_W-1:0] wr_word, rd_word;
	logic [WAKE_CNT_W-1:0] wake_last;

	// Period length lookup per select code
	function automatic logic [WAKE_CNT_W-1:0] wake_ticks(input logic [WAKE_PERIOD_W-1:0] sel);
		logic [WAKE_CNT_W-1:0] t;
		t = WAKE_TICKS_7;
		unique case (sel)
			3'h1: t = WAKE_TICKS_1;
			3'h2: t = WAKE_TICKS_2;
			3'h3: t = WAKE_TICKS_3;
			3'h4: t = WAKE_TICKS_4;
			3'h5: t = WAKE_TICKS_5;
			3'h6: t = WAKE_TICKS_6;
			3'h7: t = WAKE_TICKS_7;
			3'h0: t = WAKE_TICKS_7;
		endcase
		return t;
	endfunction

	// Write happens once both address and data are held
	assign wr_fire = !aw_free_q && !w_free_q && !bvalid_q;
	assign wr_word = aw_addr_q & ADDR_WORD_MASK;
	assign wr_hit_pin = wr_fire && w_lane0_q && (wr_word == OFF_PIN_CTRL);
	assign wr_hit_rcs = wr_fire && w_lane0_q && (wr_word == OFF_RESET_CAUSE);
	assign wr_hit_wake = wr_fire && w_lane0_q && (wr_word == OFF_WAKE_CTRL);
	assign wr_mapped = (wr_word == OFF_PIN_CTRL) || (wr_word == OFF_RESET_CAUSE) ||
		(wr_word == OFF_WAKE_CTRL);
	assign rd_fire = i_s_axi_arvalid && arready_q;
	assign rd_word = i_s_axi_araddr & ADDR_WORD_MASK;

	// Write address channel
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			aw_free_q <= 1'b1;
			aw_addr_q <= '0;
		end else if (i_s_axi_awvalid && aw_free_q) begin
			aw_free_q <= 1'b0;
			aw_addr_q <= i_s_axi_awaddr;
		end else if (wr_fire) begin
			aw_free_q <= 1'b1;
		end
	end

	// Write data channel, only the low byte lane carries register data
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			w_free_q <= 1'b1;
			w_data_q <= '0;
			w_lane0_q <= 1'b0;
		end else if (i_s_axi_wvalid && w_free_q) begin
			w_free_q <= 1'b0;
			w_data_q <= i_s_axi_wdata[REG_W-1:0];
			w_lane0_q <= i_s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_free_q <= 1'b1;
		end
	end

	// Write response, unmapped addresses answer with an error
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read data byte mux
	always_comb begin
		rd_byte = '0;
		rd_mapped = 1'b1;
		unique case (rd_word)
			OFF_PIN_CTRL: begin
				// [R25] Unused pin bits zero
				rd_byte[PIN_PULL_DISABLE_BIT] = pin_pull_disable_q;
				rd_byte[PIN_FUNC_ENABLE_BIT] = pin_func_enable_q;
				rd_byte[PIN_EVENT_FLAG_BIT] = pin_event_flag_q;
				rd_byte[PIN_IRQ_ENABLE_BIT] = pin_irq_enable_q;
				rd_byte[PIN_DETECT_MODE_BIT] = pin_detect_mode_q;
			end
			OFF_RESET_CAUSE: begin
				rd_byte = rcs_q;
			end
			OFF_WAKE_CTRL: begin
				rd_byte[WAKE_FLAG_BIT] = wake_flag_q;
				rd_byte[WAKE_CLKSEL_BIT] = wake_clksel_q;
				rd_byte[WAKE_IRQ_ENABLE_BIT] = wake_irq_enable_q;
				rd_byte[WAKE_PERIOD_LSB +: WAKE_PERIOD_W] = wake_period_q;
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	// Read channel, answer on the same edge that takes the address
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (rd_fire) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
			rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && i_s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// Pin register control bits; bit 5 is not stored
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pin_pull_disable_q <= 1'b0;
			pin_func_enable_q <= 1'b0;
			pin_irq_enable_q <= 1'b0;
			pin_detect_mode_q <= 1'b0;
		end else if (wr_hit_pin) begin
			pin_pull_disable_q <= w_data_q[PIN_PULL_DISABLE_BIT];
			// [R8] Pin function enable
			pin_func_enable_q <= w_data_q[PIN_FUNC_ENABLE_BIT];
			pin_irq_enable_q <= w_data_q[PIN_IRQ_ENABLE_BIT];
			pin_detect_mode_q <= w_data_q[PIN_DETECT_MODE_BIT];
		end
	end

	// Pin event detection
	assign pin_low = !i_ext_irq_pin_b;
	// [R13] Edge or edge-and-level
	assign pin_event = pin_func_enable_q &&
		((pin_prev_q && pin_low) || (pin_detect_mode_q && pin_low));
	// [R10] Write one acknowledges
	assign pin_ack = wr_hit_pin && w_data_q[PIN_EVENT_ACK_BIT];

	// Previous pin level for falling edge, idle high
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pin_prev_q <= 1'b1;
		end else begin
			pin_prev_q <= i_ext_irq_pin_b;
		end
	end

	// Pin event flag, a new event wins over acknowledge
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pin_event_flag_q <= 1'b0;
		end else if (pin_event) begin
			// [R9] Flag set on event
			pin_event_flag_q <= 1'b1;
		end else if (pin_ack && !(pin_detect_mode_q && pin_low)) begin
			// [R11] Level holds flag
			pin_event_flag_q <= 1'b0;
		end
	end

	// Pin outputs: pull-up control and interrupt request
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pin_pullup_en_q <= 1'b0;
			pin_irq_q <= 1'b0;
		end else begin
			// [R7] Pull-up disable
			pin_pullup_en_q <= pin_func_enable_q && !pin_pull_disable_q;
			// [R12] Request while flagged
			pin_irq_q <= pin_event_flag_q && pin_irq_enable_q;
		end
	end

	// Reset causes as seen on the last cycle of reset
	always_comb begin
		rcs_sources = RCS_CLEAR_VALUE;
		// [R18] External pin
		rcs_sources[RCS_EXT_PIN_BIT] = !i_ext_reset_pin_b;
		// [R19] Watchdog when enabled
		rcs_sources[RCS_WATCHDOG_BIT] = i_watchdog_timeout && i_watchdog_enable;
		// [R20] Illegal opcode sources
		rcs_sources[RCS_ILLEGAL_OPCODE_BIT] = i_illegal_opcode ||
			(i_stop_exec && !i_stop_instruction_enable) ||
			(i_background_instruction && !i_background_mode_enable);
		// [R21] Illegal address
		rcs_sources[RCS_ILLEGAL_ADDR_BIT] = i_illegal_address;
	end

	// Reset cause status, captured every cycle while reset is held
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			if (i_power_on_reset) begin
				// [R16] Power-on value
				rcs_q <= RCS_POR_VALUE;
			end else if (i_debug_force_reset_bit) begin
				// [R14] Forced reset clears
				rcs_q <= RCS_CLEAR_VALUE;
			end else if (i_supply_below_trip && i_low_voltage_reset_enable) begin
				// [R22] Low-voltage reset, power-on bit kept
				// [R23] Cause recorded only
				rcs_q <= RCS_CLEAR_VALUE;
				rcs_q[RCS_POWER_ON_BIT] <= rcs_q[RCS_POWER_ON_BIT];
				rcs_q[RCS_LOW_VOLTAGE_BIT] <= 1'b1;
			end else begin
				// [R17] Other resets
				rcs_q <= rcs_sources;
			end
		end
	end

	// Watchdog restart pulse, status contents untouched
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			watchdog_restart_q <= 1'b0;
		end else begin
			// [R15] Write restarts watchdog
			watchdog_restart_q <= wr_hit_rcs;
		end
	end

	// Wake-up timer control bits
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			wake_clksel_q <= WAKE_CTRL_RST[WAKE_CLKSEL_BIT];
			wake_irq_enable_q <= WAKE_CTRL_RST[WAKE_IRQ_ENABLE_BIT];
			wake_period_q <= WAKE_CTRL_RST[WAKE_PERIOD_LSB +: WAKE_PERIOD_W];
		end else if (wr_hit_wake) begin
			wake_clksel_q <= w_data_q[WAKE_CLKSEL_BIT];
			wake_irq_enable_q <= w_data_q[WAKE_IRQ_ENABLE_BIT];
			// [R3] Period select
			wake_period_q <= w_data_q[WAKE_PERIOD_LSB +: WAKE_PERIOD_W];
		end
	end

	// [R2] External tick gated by mode
	assign ext_ok = (i_stop_mode == ISC_RUN_WAIT) ||
		((i_stop_mode == ISC_STOP3) && i_ext_ref_stop_keepalive);
	// [R1] Clock source select
	assign wake_tick = wake_clksel_q ? (i_external_oscillator_tick && ext_ok) : i_lpo_1khz_tick;
	// [R24] Divider ratio lookup
	assign wake_last = wake_ticks(wake_period_q) - 11'h001;
	// [R4] Zero select disables
	assign wake_expire = (wake_period_q != 3'h0) && wake_tick && (wake_cnt_q >= wake_last);
	assign wake_restart = wr_hit_wake || (wake_period_q == 3'h0);
	assign wake_ack = wr_hit_wake && w_data_q[WAKE_ACK_BIT];

	// Wake-up period counter, restarted by any control write that strobes byte lane 0
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			wake_cnt_q <= '0;
		end else if (wake_restart || wake_expire) begin
			wake_cnt_q <= '0;
		end else if (wake_tick) begin
			wake_cnt_q <= wake_cnt_q + 11'h001;
		end
	end

	// Wake-up expiry flag, expiry wins over acknowledge
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			wake_flag_q <= 1'b0;
		end else if (wake_expire) begin
			wake_flag_q <= 1'b1;
		end else if (wake_ack) begin
			// [R5] Acknowledge clears flag
			wake_flag_q <= 1'b0;
		end
	end

	// Wake-up interrupt request
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			wakeup_irq_q <= 1'b0;
		end else begin
			// [R5] Local enable masks
			wakeup_irq_q <= wake_flag_q && wake_irq_enable_q;
		end
	end

	// Outputs straight from flops
	assign o_s_axi_awready = aw_free_q;
	assign o_s_axi_wready = w_free_q;
	assign o_s_axi_bvalid = bvalid_q;
	assign o_s_axi_bresp = bresp_q;
	assign o_s_axi_arready = arready_q;
	assign o_s_axi_rvalid = rvalid_q;
	assign o_s_axi_rdata = rdata_q;
	assign o_s_axi_rresp = rresp_q;
	assign o_pin_pullup_en = pin_pullup_en_q;
	assign o_pin_irq = pin_irq_q;
	assign o_wakeup_irq = wakeup_irq_q;
	assign o_watchdog_restart = watchdog_restart_q;

endmodule

// ===== hw/isc_pkg.sv
package isc_pkg;

	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_PIN_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_RESET_CAUSE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_WAKE_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_WORD_MASK = 8'hFC;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// External pin interrupt status/control fields
	localparam int PIN_PULL_DISABLE_BIT = 6;
	localparam int PIN_FUNC_ENABLE_BIT = 4;
	localparam int PIN_EVENT_FLAG_BIT = 3;
	localparam int PIN_EVENT_ACK_BIT = 2;
	localparam int PIN_IRQ_ENABLE_BIT = 1;
	localparam int PIN_DETECT_MODE_BIT = 0;

	// Reset cause status fields and values
	localparam int RCS_POWER_ON_BIT = 7;
	localparam int RCS_EXT_PIN_BIT = 6;
	localparam int RCS_WATCHDOG_BIT = 5;
	localparam int RCS_ILLEGAL_OPCODE_BIT = 4;
	localparam int RCS_ILLEGAL_ADDR_BIT = 3;
	localparam int RCS_LOW_VOLTAGE_BIT = 1;
	localparam logic [REG_W-1:0] RCS_POR_VALUE = 8'h82;
	localparam logic [REG_W-1:0] RCS_CLEAR_VALUE = 8'h00;

	// Wake-up timer control fields
	localparam int WAKE_FLAG_BIT = 7;
	localparam int WAKE_ACK_BIT = 6;
	localparam int WAKE_CLKSEL_BIT = 5;
	localparam int WAKE_IRQ_ENABLE_BIT = 4;
	localparam int WAKE_PERIOD_LSB = 0;
	localparam int WAKE_PERIOD_W = 3;
	localparam logic [REG_W-1:0] WAKE_CTRL_RST = 8'h00;

	// Wake-up period lengths in source clock ticks, per select code
	localparam int WAKE_CNT_W = 11;
	localparam logic [WAKE_CNT_W-1:0] WAKE_TICKS_1 = 11'h008;
	localparam logic [WAKE_CNT_W-1:0] WAKE_TICKS_2 = 11'h020;
	localparam logic [WAKE_CNT_W-1:0] WAKE_TICKS_3 = 11'h040;
	localparam logic [WAKE_CNT_W-1:0] WAKE_TICKS_4 = 11'h080;
	localparam logic [WAKE_CNT_W-1:0] WAKE_TICKS_5 = 11'h100;
	localparam logic [WAKE_CNT_W-1:0] WAKE_TICKS_6 = 11'h200;
	localparam logic [WAKE_CNT_W-1:0] WAKE_TICKS_7 = 11'h400;

	// Power modes seen by the wake-up timer
	typedef enum logic [1:0] {
		ISC_RUN_WAIT,
		ISC_STOP3,
		ISC_STOP2,
		ISC_STOP1
	} isc_stop_e;

endpackage

// ===== tb/isc_sys_ctrl_chk.sv
`timescale 1ns/1ps
module isc_sys_ctrl_chk import isc_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic [isc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic [isc_pkg::DATA_W-1:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [isc_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input wire logic o_s_axi_rvalid,
	input wire logic [isc_pkg::DATA_W-1:0] o_s_axi_rdata,
	input wire logic i_ext_irq_pin_b,
	input wire logic o_pin_pullup_en,
	input wire logic o_pin_irq,
	input wire logic o_wakeup_irq,
	input wire logic o_watchdog_restart
);
	logic [7:0] wa_q, ra_q, wd_q, pin_q, wake_q;
	logic ws_q, bv_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	// Shadow copies of control registers, one cycle behind each write
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			wa_q <= 8'h00;
			ra_q <= 8'h00;
			wd_q <= 8'h00;
			pin_q <= 8'h00;
			wake_q <= 8'h00;
			ws_q <= 1'h0;
			bv_q <= 1'h0;
		end else begin
			bv_q <= o_s_axi_bvalid;
			if (i_s_axi_awvalid && o_s_axi_awready)
				wa_q <= i_s_axi_awaddr;
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				wd_q <= i_s_axi_wdata[7:0];
				ws_q <= i_s_axi_wstrb[0];
			end
			if (i_s_axi_arvalid && o_s_axi_arready)
				ra_q <= i_s_axi_araddr;
			if (o_s_axi_bvalid && !bv_q && ws_q && wa_q == OFF_PIN_CTRL)
				pin_q <= wd_q;
			if (o_s_axi_bvalid && !bv_q && ws_q && wa_q == OFF_WAKE_CTRL)
				wake_q <= wd_q;
		end
	end

	// First cycle of a response to a write
	sequence s_write_done;
		o_s_axi_bvalid && !bv_q && ws_q;
	endsequence

	sequence s_cause_write;
		s_write_done and (wa_q == OFF_RESET_CAUSE);
	endsequence

	chk_wd_restart: assert property (s_cause_write |-> o_watchdog_restart)
		else $error("no watchdog restart after cause write");
	chk_wd_single: assert property (o_watchdog_restart |=> !o_watchdog_restart)
		else $error("watchdog restart longer than one cycle");
	chk_pull_map: assert property (o_pin_pullup_en == (pin_q[4] && !pin_q[6]))
		else $error("pull-up enable wrong for pin settings");
	chk_irq_mask: assert property (o_pin_irq |-> pin_q[1])
		else $error("pin request while masked");
	chk_fall_event: assert property (pin_q[4] && pin_q[1] && $fell(i_ext_irq_pin_b) |-> ##[1:2] o_pin_irq)
		else $error("falling edge gave no pin request");
	chk_level_hold: assert property (pin_q[0] && !i_ext_irq_pin_b && o_pin_irq
		&& !(o_s_axi_bvalid && !bv_q) |=> o_pin_irq)
		else $error("pin request dropped while pin low");
	chk_wake_mask: assert property (o_wakeup_irq |-> wake_q[4])
		else $error("wake-up request while masked");
	chk_rdata_high: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	chk_pin_rsvd: assert property (o_s_axi_rvalid && ra_q == OFF_PIN_CTRL |->
		!o_s_axi_rdata[5] && !o_s_axi_rdata[2])
		else $error("pin register reserved or ack bit read high");
endmodule

bind isc_sys_ctrl isc_sys_ctrl_chk u_chk (
	.i_ref_clk, .i_rst_b, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
	.i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb, .o_s_axi_bvalid,
	.i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr, .o_s_axi_rvalid, .o_s_axi_rdata,
	.i_ext_irq_pin_b, .o_pin_pullup_en, .o_pin_irq, .o_wakeup_irq, .o_watchdog_restart
);

// ===== tb/isc_pin_src.sv
`timescale 1ns/1ps
module isc_pin_src #(
	parameter bit EXT_PULL = 1'h1
) (
	input wire logic i_ref_clk,
	input wire logic i_drive_low,
	input wire logic i_pullup_en,
	output logic o_pin_b
);
	logic flip_q = 1'h0;

	// Pattern for an undriven line with no pull
	always_ff @(posedge i_ref_clk) begin
		flip_q <= !flip_q;
	end

	// internal or external pull holds line
	always_comb begin
		if (i_drive_low) begin
			o_pin_b = 1'h0;
		end else if (i_pullup_en || EXT_PULL) begin
			o_pin_b = 1'h1;
		end else begin
			o_pin_b = flip_q;
		end
	end
endmodule

// ===== tb/test_irq_pin_rti_reset_status.sv
`timescale 1ns/1ps
module test_irq_pin_rti_reset_status import isc_pkg::*;;
	logic clk = 1'h0, rst_b = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
	logic lpo = 1'h0, ext = 1'h0, keep = 1'h0, drv = 1'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wda = 32'h0, rda;
	logic [12:0] src = 13'h0100;
	isc_stop_e stop = ISC_RUN_WAIT;
	logic awr, wrd, bv, arr, rv, pull, pirq, wirq, wdr, pin_b;
	logic [1:0] brs, rrs;
	int error_cnt = 0, n_compared = 0, cyc = 0, wdc = 0, nt;
	// Reset source inputs and expected cause value per case
	localparam logic [20:0] RST_TAB [14] = '{21'h110082, 21'h0D0082, 21'h000040, 21'h020000,
		21'h01C020, 21'h018000, 21'h012010, 21'h011010, 21'h011800, 21'h010410, 21'h010600,
		21'h000148, 21'h0D0002, 21'h090000};

	always #2 clk = ~clk;

	isc_sys_ctrl u_dut (
		.i_ref_clk(clk), .i_rst_b(rst_b), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_awaddr(awa), .i_s_axi_awprot(3'h0), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd),
		.i_s_axi_wdata(wda), .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
		.o_s_axi_bresp(brs), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
		.i_s_axi_arprot(3'h0), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rda),
		.o_s_axi_rresp(rrs), .i_ext_irq_pin_b(pin_b), .o_pin_pullup_en(pull), .o_pin_irq(pirq),
		.i_lpo_1khz_tick(lpo), .i_external_oscillator_tick(ext), .i_ext_ref_stop_keepalive(keep),
		.i_stop_mode(stop), .o_wakeup_irq(wirq), .i_power_on_reset(src[12]),
		.i_supply_below_trip(src[11]), .i_low_voltage_reset_enable(src[10]),
		.i_debug_force_reset_bit(src[9]), .i_ext_reset_pin_b(src[8]),
		.i_watchdog_timeout(src[7]), .i_watchdog_enable(src[6]), .i_illegal_opcode(src[5]),
		.i_stop_exec(src[4]), .i_stop_instruction_enable(src[3]),
		.i_background_instruction(src[2]), .i_background_mode_enable(src[1]),
		.i_illegal_address(src[0]), .o_watchdog_restart(wdr)
	);

	isc_pin_src u_pin (.i_ref_clk(clk), .i_drive_low(drv), .i_pullup_en(pull), .o_pin_b(pin_b));

	// Verdict and end of run
	task automatic results();
		$display("Mismatches %0d, comparisons %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Register write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		@(posedge clk);
		awa <= a;
		wda <= {24'h0, d};
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (awv && awr)
				awv <= 1'h0;
			if (wv && wrd)
				wv <= 1'h0;
		end while (bv !== 1'h1 && n < 40);
		bre <= 1'h0;
		check({32'h0, brs}, {32'h0, er});
		check(34'(n < 40), 34'h1);
	endtask

	// Register read and compare
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'h1;
		rre <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (arv && arr)
				arv <= 1'h0;
		end while (rv !== 1'h1 && n < 40);
		rre <= 1'h0;
		check({rrs, rda}, {er, 24'h0, e});
		check(34'(n < 40), 34'h1);
	endtask

	task automatic reset_with(input logic [12:0] v);
		@(posedge clk);
		src <= v;
		rst_b <= 1'h0;
		repeat (6) @(posedge clk);
		rst_b <= 1'h1;
		src <= 13'h0100;
	endtask

	// One-cycle source ticks, one every two cycles
	task automatic tick(input int n, input logic e);
		repeat (n) begin
			@(posedge clk);
			lpo <= !e;
			ext <= e;
			@(posedge clk);
			lpo <= 1'h0;
			ext <= 1'h0;
		end
	endtask

	task automatic pin(input logic v);
		@(posedge clk);
		drv <= v;
		repeat (3) @(posedge clk);
	endtask

	// Watchdog restart pulses and hang guard
	always @(posedge clk) begin
		cyc++;
		if (wdr === 1'h1)
			wdc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	initial begin
		reset_with(13'h1100);
		rd(OFF_RESET_CAUSE, 8'h82);
		rd(OFF_PIN_CTRL, 8'h00);
		rd(OFF_WAKE_CTRL, 8'h00);
		wr(OFF_RESET_CAUSE, 8'hFF);
		rd(OFF_RESET_CAUSE, 8'h82);
		check(34'(wdc), 34'h1);
		wr(8'h0C, 8'h5A, RESP_SLVERR);
		rd(8'h0C, 8'h00, RESP_SLVERR);
		wr(OFF_PIN_CTRL, 8'h12);
		pin(1'h1);
		pin(1'h0);
		check(34'(pull), 34'h1);
		check(34'(pirq), 34'h1);
		rd(OFF_PIN_CTRL, 8'h1A);
		wr(OFF_PIN_CTRL, 8'h16);
		rd(OFF_PIN_CTRL, 8'h12);
		check(34'(pirq), 34'h0);
		wr(OFF_PIN_CTRL, 8'h52);
		pin(1'h1);
		check(34'(pull), 34'h0);
		wr(OFF_PIN_CTRL, 8'h16);
		rd(OFF_PIN_CTRL, 8'h12);
		wr(OFF_PIN_CTRL, 8'h13);
		wr(OFF_PIN_CTRL, 8'h17);
		rd(OFF_PIN_CTRL, 8'h1B);
		pin(1'h0);
		wr(OFF_PIN_CTRL, 8'h17);
		rd(OFF_PIN_CTRL, 8'h13);
		wr(OFF_PIN_CTRL, 8'h01);
		pin(1'h1);
		pin(1'h0);
		rd(OFF_PIN_CTRL, 8'h01);
		wr(OFF_PIN_CTRL, 8'h10);
		pin(1'h1);
		pin(1'h0);
		rd(OFF_PIN_CTRL, 8'h18);
		check(34'(pirq), 34'h0);
		// Every period code on the internal tick
		for (int c = 1; c < 8; c++) begin
			nt = (c == 1) ? 8 : (16 << (c - 1));
			wr(OFF_WAKE_CTRL, 8'h10 | 8'(c));
			tick(nt - 1, 1'h0);
			rd(OFF_WAKE_CTRL, 8'h10 | 8'(c));
			tick(1, 1'h0);
			rd(OFF_WAKE_CTRL, 8'h90 | 8'(c));
			check(34'(wirq), 34'h1);
			wr(OFF_WAKE_CTRL, 8'h50 | 8'(c));
			rd(OFF_WAKE_CTRL, 8'h10 | 8'(c));
		end
		wr(OFF_WAKE_CTRL, 8'h21);
		tick(8, 1'h0);
		rd(OFF_WAKE_CTRL, 8'h21);
		stop <= ISC_STOP2;
		tick(8, 1'h1);
		rd(OFF_WAKE_CTRL, 8'h21);
		stop <= ISC_STOP3;
		keep <= 1'h1;
		tick(8, 1'h1);
		rd(OFF_WAKE_CTRL, 8'hA1);
		check(34'(wirq), 34'h0);
		wr(OFF_WAKE_CTRL, 8'h41);
		stop <= ISC_STOP1;
		tick(8, 1'h0);
		rd(OFF_WAKE_CTRL, 8'h81);
		wr(OFF_WAKE_CTRL, 8'h50);
		stop <= ISC_RUN_WAIT;
		tick(20, 1'h0);
		rd(OFF_WAKE_CTRL, 8'h10);
		check(34'(wirq), 34'h0);
		// Reset causes, one case per table row
		for (int i = 0; i < 14; i++) begin
			reset_with(RST_TAB[i][20:8]);
			rd(OFF_RESET_CAUSE, RST_TAB[i][7:0]);
		end
		results();
	end
endmodule
